// ===== bts_pkg.sv
// Constants, enumerations and carriers for the timestamp clock
package bts_pkg;

  // Time base
  localparam int unsigned SEC_NS      = 1_000_000_000;
  localparam int unsigned CLK_NS      = 8;
  localparam int unsigned CYC_PER_SEC = SEC_NS / CLK_NS;

  // Counter layout and reset value
  localparam int unsigned TIME_W     = 32;
  localparam logic [31:0] TIME_RESET = 32'h0000_0000;
  localparam logic [31:0] TIME_ONE   = 32'h0000_0001;

  // Pin synchroniser depth
  localparam int unsigned SYNC_DEPTH = 3;

  // Management commands that reach the counter
  typedef enum logic [1:0] {
    BTS_OP_GET_SEL = 2'b00,
    BTS_OP_GET_SDR = 2'b01,
    BTS_OP_SET_SEL = 2'b10,
    BTS_OP_NONE    = 2'b11
  } bts_op_e;

  // Seeding state machine
  typedef enum logic [1:0] {
    BTS_ST_SEED = 2'b00,
    BTS_ST_READ = 2'b01,
    BTS_ST_RUN  = 2'b10
  } bts_state_e;

  typedef struct packed {
    bts_op_e     op;
    logic [31:0] value;
  } bts_cmd_s;

  typedef struct packed {
    bts_op_e     op;
    logic [31:0] value;
  } bts_rsp_s;

endpackage

// ===== bts_sec_tick.sv
// One-second enable pulse divided from the controller clock
`timescale 1ns/1ps
`default_nettype none

module bts_sec_tick #(
  parameter int unsigned CYCLES = bts_pkg::CYC_PER_SEC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Enable out
  output var  logic tick
);

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic          tick_ff;

  // Free-running divider, one pulse per wrap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == LAST) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + CW'(1);
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

  tick_gap_a: assert property (@(posedge clk) disable iff (!resetn)
    tick_ff |=> !tick_ff || (CYCLES == 1))
    else $error("second tick repeated too soon");

endmodule

`default_nettype wire

// ===== bts_timestamp.sv
// Timestamp clock: seeds from the system clock, counts seconds, serves commands
//
// Operation
// - Seed counter from system clock after reset
// - No clock read while self-test busy and not done
// - Abandon pending read when done deasserts
// - Self-test running at seed: clear, count up
// - Set command touches only internal counter
// - Both get commands return counter value
// - Initiating master recovers a hung bus
`timescale 1ns/1ps
`default_nettype none

module bts_timestamp #(
  parameter int unsigned CYCLES_PER_SEC = bts_pkg::CYC_PER_SEC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Host boot status pins
  input  wire logic              selftest_done_pin,
  input  wire logic              selftest_busy_pin,
  // Management command port
  input  wire logic              cmd_valid,
  input  wire bts_pkg::bts_cmd_s cmd,
  output var  logic              rsp_valid,
  output var  bts_pkg::bts_rsp_s rsp,
  // System clock read over the shared host bus
  output var  logic              rtc_rd_req,
  output var  logic              rtc_rd_abort,
  input  wire logic              rtc_rd_done,
  input  wire logic              rtc_rd_err,
  input  wire logic [31:0]       rtc_rd_data,
  // Bus hang handling
  input  wire logic              bus_hung,
  output var  logic              bus_recover,
  // Status
  output var  logic [31:0]       time_now,
  output var  logic              seeded
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [bts_pkg::SYNC_DEPTH-1:0] done_sync_ff;
  logic [bts_pkg::SYNC_DEPTH-1:0] busy_sync_ff;
  logic                           done_ff;
  logic                           busy_ff;
  logic                           done_prev_ff;

  // Three stages; a level is taken only once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_sync_ff <= '0;
      busy_sync_ff <= '0;
    end else begin
      done_sync_ff <= {done_sync_ff[1:0], selftest_done_pin};
      busy_sync_ff <= {busy_sync_ff[1:0], selftest_busy_pin};
    end
  end

  // Filtered levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_ff      <= 1'b0;
      busy_ff      <= 1'b0;
      done_prev_ff <= 1'b0;
    end else begin
      done_prev_ff <= done_ff;
      if (done_sync_ff[1] == done_sync_ff[2]) done_ff <= done_sync_ff[2];
      if (busy_sync_ff[1] == busy_sync_ff[2]) busy_ff <= busy_sync_ff[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Second tick

  logic tick;

  bts_sec_tick #(
    .CYCLES (CYCLES_PER_SEC)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tick   (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Seeding sequence

  bts_pkg::bts_state_e state_ff;
  logic                rd_req_ff;
  logic                rd_abort_ff;
  logic                cmd_set;
  logic                cmd_get;
  logic                host_busy;
  logic                read_cancel;
  logic                done_fall;
  logic [2:0]          settle_ff;

  // Filters need SYNC_DEPTH+1 edges after reset before their levels are real
  localparam logic [2:0] SETTLE_LAST = 3'(bts_pkg::SYNC_DEPTH + 1);

  assign cmd_set     = cmd_valid && (cmd.op == bts_pkg::BTS_OP_SET_SEL);
  assign cmd_get     = cmd_valid && (cmd.op == bts_pkg::BTS_OP_GET_SEL || cmd.op == bts_pkg::BTS_OP_GET_SDR);
  // Host owns the bus while its self-test runs and is not yet done
  assign host_busy   = busy_ff && !done_ff;
  // A new boot or a dropped done flag means the host wants the bus back
  assign done_fall   = done_prev_ff && !done_ff;
  assign read_cancel = (!done_ff && busy_ff) || done_fall;

  // State and read request move together so the request never outlives READ
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff    <= bts_pkg::BTS_ST_SEED;
      settle_ff   <= '0;
      rd_req_ff   <= 1'b0;
      rd_abort_ff <= 1'b0;
    end else begin
      rd_abort_ff <= 1'b0;
      case (state_ff)
        bts_pkg::BTS_ST_SEED: begin
          if (host_busy) begin
            state_ff <= bts_pkg::BTS_ST_RUN;
          end else if (cmd_set) begin
            state_ff <= bts_pkg::BTS_ST_RUN;
          end else if (settle_ff != SETTLE_LAST) begin
            settle_ff <= settle_ff + 3'h1;
          end else begin
            state_ff  <= bts_pkg::BTS_ST_READ;
            rd_req_ff <= 1'b1;
          end
        end
        bts_pkg::BTS_ST_READ: begin
          if (read_cancel || cmd_set) begin
            state_ff    <= bts_pkg::BTS_ST_RUN;
            rd_req_ff   <= 1'b0;
            rd_abort_ff <= 1'b1;
          end else if (rtc_rd_done || rtc_rd_err) begin
            state_ff  <= bts_pkg::BTS_ST_RUN;
            rd_req_ff <= 1'b0;
          end
        end
        default: begin
          state_ff  <= bts_pkg::BTS_ST_RUN;
          rd_req_ff <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter

  logic [31:0] cnt_ff;
  logic        seeded_ff;
  logic        rd_ok;

  assign rd_ok = (state_ff == bts_pkg::BTS_ST_READ) && rtc_rd_done && !rtc_rd_err && !read_cancel && !cmd_set;

  // Loads beat the tick; a failed or cancelled read leaves the zero start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= bts_pkg::TIME_RESET;
    end else if (cmd_set) begin
      cnt_ff <= cmd.value;
    end else if (rd_ok) begin
      cnt_ff <= rtc_rd_data;
    end else if (state_ff == bts_pkg::BTS_ST_SEED && host_busy) begin
      cnt_ff <= bts_pkg::TIME_RESET;
    end else if (tick) begin
      cnt_ff <= cnt_ff + bts_pkg::TIME_ONE;
    end
  end

  // Seeded once any true time has been loaded
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seeded_ff <= 1'b0;
    end else if (cmd_set || rd_ok) begin
      seeded_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command answers

  logic              rsp_valid_ff;
  bts_pkg::bts_rsp_s rsp_ff;

  // One answer per get or set command, one cycle after it; set echoes the written time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff       <= '{op: bts_pkg::BTS_OP_NONE, value: bts_pkg::TIME_RESET};
    end else begin
      rsp_valid_ff <= cmd_get || cmd_set;
      if (cmd_get) begin
        rsp_ff <= '{op: cmd.op, value: cnt_ff};
      end else if (cmd_set) begin
        rsp_ff <= '{op: cmd.op, value: cmd.value};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus recovery

  logic recover_ff;

  // Only the read we started is ours to recover; pulses every other cycle while hung
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      recover_ff <= 1'b0;
    end else begin
      recover_ff <= bus_hung && rd_req_ff && !recover_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [31:0] time_ff;

  // Registered copy so the status port is a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      time_ff <= bts_pkg::TIME_RESET;
    end else begin
      time_ff <= cnt_ff;
    end
  end

  assign rsp_valid    = rsp_valid_ff;
  assign rsp          = rsp_ff;
  assign rtc_rd_req   = rd_req_ff;
  assign rtc_rd_abort = rd_abort_ff;
  assign bus_recover  = recover_ff;
  assign time_now     = time_ff;
  assign seeded       = seeded_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  no_early_read_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(rd_req_ff) |-> $past(!host_busy))
    else $error("clock read started while host owns the bus");

  read_cancel_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_ff == bts_pkg::BTS_ST_READ && read_cancel) |=> (!rd_req_ff && rd_abort_ff))
    else $error("pending read not abandoned");

  busy_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_ff == bts_pkg::BTS_ST_SEED && host_busy && !cmd_set) |=> (cnt_ff == 32'h0000_0000 && !rd_req_ff))
    else $error("counter not cleared while self-test runs");

  seed_load_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_ok |=> (cnt_ff == $past(rtc_rd_data) && state_ff == bts_pkg::BTS_ST_RUN))
    else $error("read time not loaded");

  set_load_a: assert property (@(posedge clk) disable iff (!resetn)
    cmd_set |=> (cnt_ff == $past(cmd.value) && !$rose(rd_req_ff)))
    else $error("set command did not load counter alone");

  get_answer_a: assert property (@(posedge clk) disable iff (!resetn)
    cmd_get |=> (rsp_valid && rsp.value == $past(cnt_ff) && rsp.op == $past(cmd.op)))
    else $error("get answer wrong");

  recover_own_a: assert property (@(posedge clk) disable iff (!resetn)
    recover_ff |-> $past(rd_req_ff && bus_hung))
    else $error("recovery without own transaction");

  sec_step_a: assert property (@(posedge clk) disable iff (!resetn)
    (tick && !cmd_set && !rd_ok && state_ff == bts_pkg::BTS_ST_RUN) |=> (cnt_ff == $past(cnt_ff) + 32'h0000_0001))
    else $error("counter did not step on tick");

  hold_count_a: assert property (@(posedge clk) disable iff (!resetn)
    (!tick && !cmd_set && !rd_ok && state_ff == bts_pkg::BTS_ST_RUN) |=> $stable(cnt_ff))
    else $error("counter moved without tick");

  read_end_a: assert property (@(posedge clk) disable iff (!resetn)
    (rd_req_ff && (rtc_rd_done || rtc_rd_err)) |=> !rd_req_ff)
    else $error("read request held after completion");

  seed_read_c: cover property (@(posedge clk) disable iff (!resetn) rd_ok);
  seed_zero_c: cover property (@(posedge clk) disable iff (!resetn)
    state_ff == bts_pkg::BTS_ST_SEED && host_busy);
  cancel_c:    cover property (@(posedge clk) disable iff (!resetn) rd_abort_ff);
  recover_c:   cover property (@(posedge clk) disable iff (!resetn) recover_ff);

endmodule

`default_nettype wire

// ===== bts_rtc_model.sv
// Behavioural system clock answering the seed read
`timescale 1ns/1ps
`default_nettype none

module bts_rtc_model (
  // Clock
  input  wire logic        clk,
  // Read handshake
  input  wire logic        rd_req,
  output var  logic        rd_done,
  output var  logic        rd_err,
  output var  logic [31:0] rd_data,
  // Bench controls
  input  wire logic [7:0]  delay,
  input  wire logic        fail,
  input  wire logic [31:0] now,
  output var  int          reads
);
  int age;

  initial begin
    rd_done = 1'h0;
    rd_err  = 1'h0;
    rd_data = 32'h0000_0000;
    age     = 0;
    reads   = 0;
  end

  ////////////////////////////////////////
  // Idle data inverts so stale bits never look valid
  always @(negedge clk) begin
    rd_done <= 1'h0;
    rd_err  <= 1'h0;
    rd_data <= ~rd_data;
    age     <= rd_req ? age + 1 : 0;
    if (rd_req && age == 0) begin
      reads <= reads + 1;
    end
    // Answer only while asked; a dropped request is never answered
    if (rd_req && age + 1 == int'(delay)) begin
      rd_done <= !fail;
      rd_err  <= fail;
      rd_data <= now;
    end
  end
endmodule

`default_nettype wire

// ===== bts_timestamp_tb.sv
// Self-checking bench for the timestamp clock
`timescale 1ns/1ps
`default_nettype none

module bts_timestamp_tb;
  localparam int unsigned CPS = 8;

  typedef struct {
    bts_pkg::bts_op_e op;
    logic [31:0]      v;
    logic             ans;
  } bts_row_s;

  logic              clk, resetn, done_pin, busy_pin, bus_hung, bus_recover, seeded;
  logic              cmd_valid, rsp_valid, rd_req, rd_abort, rd_done, rd_err, m_fail;
  logic [31:0]       rd_data, time_now, m_now, t0;
  logic [7:0]        m_delay;
  bts_pkg::bts_cmd_s cmd;
  bts_pkg::bts_rsp_s rsp;
  int                num_errors, cmp_count, m_reads, r0, n;
  bts_row_s          rows [4] = '{
    '{bts_pkg::BTS_OP_GET_SEL, 32'h1234_5678, 1'h1},
    '{bts_pkg::BTS_OP_GET_SDR, 32'h0000_0000, 1'h1},
    '{bts_pkg::BTS_OP_GET_SEL, 32'hFFFF_FFFF, 1'h1},
    '{bts_pkg::BTS_OP_NONE,    32'hA5A5_5A5A, 1'h0}
  };

  // Short second keeps the run brief
  bts_timestamp #(.CYCLES_PER_SEC(CPS)) uut (
    .clk(clk), .resetn(resetn), .selftest_done_pin(done_pin), .selftest_busy_pin(busy_pin),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
    .rtc_rd_req(rd_req), .rtc_rd_abort(rd_abort), .rtc_rd_done(rd_done), .rtc_rd_err(rd_err),
    .rtc_rd_data(rd_data), .bus_hung(bus_hung), .bus_recover(bus_recover),
    .time_now(time_now), .seeded(seeded)
  );

  bts_rtc_model rtc (
    .clk(clk), .rd_req(rd_req), .rd_done(rd_done), .rd_err(rd_err), .rd_data(rd_data),
    .delay(m_delay), .fail(m_fail), .now(m_now), .reads(m_reads)
  );

  ////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Six cycles of reset with the self-test pins set beforehand
  task automatic do_reset(input logic busy);
    resetn   = 1'h0;
    busy_pin = busy;
    done_pin = 1'h0;
    r0       = m_reads;
    cyc(6);
    resetn = 1'h1;
  endtask

  // Leaves the strobe high so back-to-back commands need no gap
  task automatic send(input bts_pkg::bts_op_e op, input logic [31:0] v);
    cmd_valid = 1'h1;
    cmd.op    = op;
    cmd.value = v;
    cyc(1);
  endtask

  // Align to a fresh second so no tick lands inside a test
  task automatic sync_tick;
    logic [31:0] prev;
    prev = time_now;
    for (int k = 0; k < 2 * CPS && time_now === prev; k++) cyc(1);
    check("tick", 32'(time_now !== prev), 32'h0000_0001);
  endtask

  ////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    $display("unexpected watchdog: tests did not finish");
    wrap_up();
  end

  initial begin
    resetn    = 1'h0;
    busy_pin  = 1'h0;
    done_pin  = 1'h0;
    bus_hung  = 1'h0;
    cmd_valid = 1'h0;
    cmd       = '{op: bts_pkg::BTS_OP_NONE, value: 32'h0000_0000};
    m_delay   = 8'h14;
    m_fail    = 1'h0;
    m_now     = 32'h5EED_0001;
    num_errors = 0;
    cmp_count  = 0;
    // Seed read, with a hang during it and one after it
    do_reset(1'h0);
    cyc(4);
    check("settle", 32'(rd_req), 32'h0000_0000);
    cyc(1);
    check("read request", 32'(rd_req), 32'h0000_0001);
    cyc(3);
    bus_hung = 1'h1;
    cyc(1);
    bus_hung = 1'h0;
    check("recover", 32'(bus_recover), 32'h0000_0001);
    for (n = 0; n < 40 && seeded !== 1'h1; n++) cyc(1);
    cyc(1);
    check("seed value", time_now, m_now);
    check("reads", 32'(m_reads - r0), 32'h0000_0001);
    bus_hung = 1'h1;
    cyc(3);
    check("idle recover", 32'(bus_recover), 32'h0000_0000);
    bus_hung = 1'h0;
    $display("test seed read done");
    // Set then get, back to back; the last row is refused
    foreach (rows[i]) begin
      sync_tick();
      send(bts_pkg::BTS_OP_SET_SEL, rows[i].v);
      check("set answer", 32'(rsp_valid), 32'h0000_0001);
      check("set echo", rsp.value, rows[i].v);
      check("set op", 32'(rsp.op), 32'(bts_pkg::BTS_OP_SET_SEL));
      send(rows[i].op, 32'h0000_0000);
      cmd_valid = 1'h0;
      check("get answer", 32'(rsp_valid), 32'(rows[i].ans));
      check("get value", rsp.value, rows[i].v);
      check("get op", 32'(rsp.op), 32'(rows[i].ans ? rows[i].op : bts_pkg::BTS_OP_SET_SEL));
      check("counter", time_now, rows[i].v);
      check("no bus read", 32'(m_reads - r0), 32'h0000_0001);
    end
    t0 = time_now;
    cyc(2 * CPS);
    check("seconds", time_now - t0, 32'h0000_0002);
    $display("test commands done");
    // Self-test running at seed: no read, count from zero, then firmware sets time
    do_reset(1'h1);
    cyc(5 * CPS);
    check("no read", 32'(m_reads - r0), 32'h0000_0000);
    check("zero start", 32'(time_now inside {[4:5]}), 32'h0000_0001);
    check("unseeded", 32'(seeded), 32'h0000_0000);
    done_pin = 1'h1;
    busy_pin = 1'h0;
    sync_tick();
    send(bts_pkg::BTS_OP_SET_SEL, 32'h6000_0000);
    cmd_valid = 1'h0;
    cyc(1);
    check("host time", time_now, 32'h6000_0000);
    check("seeded", 32'(seeded), 32'h0000_0001);
    $display("test busy boot done");
    // Failed read falls back to the zero-based count
    m_fail  = 1'h1;
    m_delay = 8'h05;
    do_reset(1'h0);
    cyc(12);
    check("err release", 32'(rd_req), 32'h0000_0000);
    check("err unseeded", 32'(seeded), 32'h0000_0000);
    check("err count", 32'(time_now < 32'h0000_0003), 32'h0000_0001);
    $display("test read error done");
    // Self-test restarts mid-read: read is abandoned
    m_fail  = 1'h0;
    m_delay = 8'h3C;
    do_reset(1'h0);
    cyc(4);
    busy_pin = 1'h1;
    for (n = 0; n < 10 && rd_abort !== 1'h1; n++) cyc(1);
    check("abort", 32'(rd_abort), 32'h0000_0001);
    check("req dropped", 32'(rd_req), 32'h0000_0000);
    check("abort read", 32'(m_reads - r0), 32'h0000_0001);
    cyc(80);
    check("no late seed", 32'(seeded), 32'h0000_0000);
    $display("test abort done");
    // Done flag dropping mid-read also abandons it
    do_reset(1'h0);
    cyc(5);
    done_pin = 1'h1;
    cyc(6);
    done_pin = 1'h0;
    for (n = 0; n < 10 && rd_abort !== 1'h1; n++) cyc(1);
    check("done drop abort", 32'(rd_abort), 32'h0000_0001);
    check("done drop req", 32'(rd_req), 32'h0000_0000);
    $display("test done drop done");
    wrap_up();
  end
endmodule

`default_nettype wire
